// [rtl/gpio_led_indicator_pins.sv]
// gpio and status led pin block with avalon-mm register access
//
// Summary of operation
// - Crossover detection is enabled while the strap is high or open and disabled when low.
// - Each of the three pins is set by software as push-pull output, open-drain output or input.
// - A pin on led duty is driven only as an open-drain output.
// - The speed indicator is high only at 10 Mb/s and low at 100 Mb/s, negotiation or no cable.
// - The link/activity indicator is held low while a valid link is present, released otherwise.
// - Activity during link drives the link/activity indicator high for an 80 ms pulse.
// - Each pulse is followed by at least 80 ms low and repeats while activity continues.
// - The duplex indicator is low in full duplex and released high otherwise.
// - Reset returns all pin configuration, indicator logic and registers to reset state.
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module gpio_led_indicator_pins
  import gpio_led_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int N_TICKS  = BLINK_TICKS
) (
  input  wire logic                clk,
  input  wire logic                reset,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]   address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  input  wire logic [3:0]          byteenable,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  // phy status, same clock
  input  wire logic                phyLinkUp,
  input  wire logic                phySpeed10,
  input  wire logic                phyAutoNegBusy,
  input  wire logic                phyFullDuplex,
  input  wire logic                phyTxActive,
  input  wire logic                phyRxActive,
  // strap pin and crossover control
  input  wire logic                crossover_auto_enable,
  output logic                     crossoverDetectEn,
  // pins
  input  wire logic [NUM_PINS-1:0] gpioIn,
  output logic      [NUM_PINS-1:0] gpioOut,
  output logic      [NUM_PINS-1:0] gpioOe
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [31:0]         cfg_ff;
  logic [NUM_PINS-1:0] data_ff;
  logic                ack_ff;
  logic [31:0]         readdata_ff;
  logic                wrEn;
  logic [31:0]         dataWord;
  logic [NUM_PINS-1:0] ledSel;
  logic [NUM_PINS-1:0] dirOut;
  logic [NUM_PINS-1:0] openDrain;
  logic [31:0]         dataMerged;

  assign ledSel    = cfg_ff[CFG_LED_LSB +: NUM_PINS];
  assign dirOut    = cfg_ff[CFG_DIR_LSB +: NUM_PINS];
  assign openDrain = cfg_ff[CFG_OD_LSB +: NUM_PINS];
  assign dataWord  = {{(32-NUM_PINS){1'b0}}, data_ff};
  assign dataMerged = mergeBytes(dataWord, writedata, byteenable);

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle per access

  assign waitrequest = (read || write) && !ack_ff;
  assign wrEn        = write && ack_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (read || write) && !ack_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration and data registers

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_ff <= CFG_RESET;
    end else if (wrEn && address == CFG_OFFSET) begin
      cfg_ff <= mergeBytes(cfg_ff, writedata, byteenable);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      data_ff <= DATA_RESET;
    end else if (wrEn && address == DATA_OFFSET) begin
      data_ff <= dataMerged[NUM_PINS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap and pin input synchronisers

  logic [NUM_PINS-1:0] pinSync;
  logic                xoverSync;

  // strap high or open enables crossover
  pin_sync #(
    .W         (1),
    .RESET_VAL (XOVER_RESET)
  ) u_xover_sync (
    .clk    (clk),
    .reset  (reset),
    .pinIn  (crossover_auto_enable),
    .pinOut (xoverSync)
  );

  pin_sync #(
    .W         (NUM_PINS),
    .RESET_VAL ('0)
  ) u_pin_sync (
    .clk    (clk),
    .reset  (reset),
    .pinIn  (gpioIn),
    .pinOut (pinSync)
  );

  assign crossoverDetectEn = xoverSync;

  ////////////////////////////////////////////////////////////////////////////
  // status indicators

  logic speedN_ff;
  logic linkActN_ff;
  logic duplexN_ff;
  logic pulseOn;

  activity_blink #(
    .TICK_CYC (TICK_CYC),
    .N_TICKS  (N_TICKS)
  ) u_blink (
    .clk      (clk),
    .reset    (reset),
    .linkUp   (phyLinkUp),
    .activity (phyTxActive || phyRxActive),
    .pulseOn  (pulseOn)
  );

  // speed high only at 10 mb/s
  always_ff @(posedge clk) begin
    if (reset) begin
      speedN_ff <= 1'b0;
    end else begin
      speedN_ff <= phyLinkUp && phySpeed10 && !phyAutoNegBusy;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      linkActN_ff <= 1'b1;
    end else begin
      linkActN_ff <= !phyLinkUp || pulseOn;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      duplexN_ff <= 1'b1;
    end else begin
      duplexN_ff <= !(phyLinkUp && phyFullDuplex);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  logic [NUM_PINS-1:0] ledVal;
  assign ledVal = {duplexN_ff, linkActN_ff, speedN_ff};

  // gpio pins follow direction and data
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (ledSel[i]) begin
        gpioOut[i] = 1'b0;
        gpioOe[i]  = !ledVal[i];
      end else begin
        gpioOut[i] = openDrain[i] ? 1'b0 : data_ff[i];
        gpioOe[i]  = dirOut[i] && (openDrain[i] ? !data_ff[i] : 1'b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0000_0000;
    case (address)
      CFG_OFFSET:  rdMux = cfg_ff & {{13{1'b0}}, 3'h7, 5'h00, 3'h7, 5'h00, 3'h7};
      DATA_OFFSET: rdMux = dataWord;
      STAT_OFFSET: begin
        rdMux[STAT_PIN_LSB +: NUM_PINS] = pinSync;
        rdMux[STAT_XOVER]               = xoverSync;
        rdMux[STAT_LINK]                = phyLinkUp;
        rdMux[STAT_FDX]                 = phyFullDuplex;
        rdMux[STAT_SPD_N]               = speedN_ff;
        rdMux[STAT_ACT_N]               = linkActN_ff;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readdata_ff <= 32'h0000_0000;
    end else if (read && !ack_ff) begin
      readdata_ff <= rdMux;
    end
  end

  assign readdata = readdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_bus_wait: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest held more than one cycle");

  chk_data_write: assert property (
    wrEn && address == DATA_OFFSET && byteenable[0]
    |=> data_ff == $past(writedata[NUM_PINS-1:0]))
    else $error("data register not updated");

  chk_speed_ind: assert property (
    phyLinkUp && phySpeed10 && !phyAutoNegBusy ##1 speedN_ff
    or (!phyLinkUp || !phySpeed10 || phyAutoNegBusy) ##1 !speedN_ff)
    else $error("speed indicator wrong");

  chk_link_low: assert property (
    !phyLinkUp |=> linkActN_ff)
    else $error("link indicator low without link");

  chk_link_on: assert property (
    phyLinkUp && !pulseOn |=> !linkActN_ff)
    else $error("link indicator not low with link");

  chk_duplex_ind: assert property (
    phyLinkUp && phyFullDuplex |=> !duplexN_ff)
    else $error("duplex indicator not low");

  chk_led_od: assert property (
    ledSel[1] |-> !gpioOut[1] && (gpioOe[1] == !linkActN_ff))
    else $error("led pin not open-drain");

  chk_push_pull: assert property (
    !ledSel[0] && dirOut[0] && !openDrain[0]
    |-> gpioOe[0] && gpioOut[0] == data_ff[0])
    else $error("push-pull pin not driven");

  chk_input_mode: assert property (
    !ledSel[2] && !dirOut[2] |-> !gpioOe[2])
    else $error("input pin driven");

  // own disable: the default one would mask every attempt
  chk_reset_cfg: assert property (@(posedge clk) disable iff (1'b0)
    reset |=> cfg_ff == CFG_RESET && data_ff == DATA_RESET && linkActN_ff)
    else $error("reset state wrong");

  cov_write_cfg: cover property (wrEn && address == CFG_OFFSET);
  cov_pulse: cover property ($rose(pulseOn) && phyLinkUp);
  cov_od_gpio: cover property (!ledSel[0] && dirOut[0] && openDrain[0]);

endmodule
`default_nettype wire

// [rtl/gpio_led_pkg.sv]
// constants shared by the gpio / status led pin block
package gpio_led_pkg;

  localparam int          NUM_PINS     = 3;
  localparam int          ADDR_W       = 4;
  localparam int          CLK_HZ       = 50_000_000;
  localparam int          TICK_US      = 1000;
  localparam int          TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          BLINK_MS     = 80;
  localparam int          BLINK_TICKS  = BLINK_MS * 1000 / TICK_US;

  localparam logic [3:0]  CFG_OFFSET   = 4'h0;
  localparam logic [3:0]  DATA_OFFSET  = 4'h4;
  localparam logic [3:0]  STAT_OFFSET  = 4'h8;

  localparam int          CFG_LED_LSB  = 0;
  localparam int          CFG_DIR_LSB  = 8;
  localparam int          CFG_OD_LSB   = 16;
  localparam int          STAT_PIN_LSB = 0;
  localparam int          STAT_XOVER   = 4;
  localparam int          STAT_LINK    = 8;
  localparam int          STAT_FDX     = 9;
  localparam int          STAT_SPD_N   = 10;
  localparam int          STAT_ACT_N   = 11;

  localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
  localparam logic [2:0]  DATA_RESET   = 3'h0;
  localparam logic        XOVER_RESET  = 1'b1;

endpackage

// [rtl/pin_sync.sv]
// three-stage synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int         W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_ff  <= RESET_VAL;
      s2_ff  <= RESET_VAL;
      s3_ff  <= RESET_VAL;
      out_ff <= RESET_VAL;
    end else begin
      s1_ff  <= pinIn;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (out_ff & (s2_ff ^ s3_ff));
    end
  end

  assign pinOut = out_ff;

endmodule
`default_nettype wire

// [rtl/activity_blink.sv]
// activity blink sequencer: pulse, then enforced low, repeat while active
`timescale 1ns/1ns
`default_nettype none
module activity_blink
  import gpio_led_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int N_TICKS  = BLINK_TICKS
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic linkUp,
  input  wire logic activity,
  output logic      pulseOn
);

  typedef enum logic [1:0] {IDLE, PULSE, HOLD} blink_e;

  blink_e      st_ff;
  logic [31:0] div_ff;
  logic [31:0] cnt_ff;
  logic        pend_ff;
  logic        tick;
  logic        last;

  assign tick = (div_ff == 32'(TICK_CYC - 1));
  assign last = tick && (cnt_ff == 32'(N_TICKS - 1));

  ////////////////////////////////////////////////////////////////////////////
  // timed pulse after activity
  always_ff @(posedge clk) begin
    if (reset || !linkUp) begin
      st_ff   <= IDLE;
      div_ff  <= '0;
      cnt_ff  <= '0;
      pend_ff <= 1'b0;
    end else begin
      case (st_ff)
        IDLE: begin
          div_ff <= '0;
          cnt_ff <= '0;
          if (activity) begin
            st_ff   <= PULSE;
            pend_ff <= 1'b0;
          end
        end
        PULSE, HOLD: begin
          pend_ff <= pend_ff | activity;
          div_ff  <= tick ? '0 : div_ff + 32'd1;
          if (tick) begin
            cnt_ff <= last ? '0 : cnt_ff + 32'd1;
          end
          if (last && st_ff == PULSE) begin
            st_ff <= HOLD;
          end else if (last) begin
            st_ff   <= (pend_ff || activity) ? PULSE : IDLE;
            pend_ff <= 1'b0;
          end
        end
        default: st_ff <= IDLE;
      endcase
    end
  end

  assign pulseOn = (st_ff == PULSE);

  ////////////////////////////////////////////////////////////////////////////
  // phase length checking
  logic [31:0] run_ff;
  always_ff @(posedge clk) begin
    if (reset || st_ff == IDLE || last) begin
      run_ff <= '0;
    end else begin
      run_ff <= run_ff + 32'd1;
    end
  end

  chk_pulse_len: assert property (@(posedge clk) disable iff (reset)
    (st_ff == PULSE && last) |-> run_ff == 32'(TICK_CYC * N_TICKS - 1))
    else $error("activity pulse length wrong");

  chk_hold_len: assert property (@(posedge clk) disable iff (reset)
    (st_ff == HOLD && last) |-> run_ff == 32'(TICK_CYC * N_TICKS - 1))
    else $error("low phase after pulse too short");

  chk_hold_first: assert property (@(posedge clk) disable iff (reset)
    (st_ff == PULSE && last && linkUp) |=> st_ff == HOLD)
    else $error("pulse not followed by low phase");

  cov_repeat: cover property (@(posedge clk) disable iff (reset)
    st_ff == HOLD && last && (pend_ff || activity));

endmodule
`default_nettype wire

// [tb/board_pins.sv]
// board side of the three pins: pull-ups, external drivers, strap resistor
`timescale 1ns/1ns
`default_nettype none
module board_pins (
  input  wire logic [2:0] pinOut,
  input  wire logic [2:0] pinOe,
  input  wire logic [2:0] extVal,
  input  wire logic [2:0] extOe,
  input  wire logic       strapOe,
  input  wire logic       strapVal,
  output logic      [2:0] pinLevel,
  output logic            strapLevel
);
  // released pins float up to the pull-up level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pinLevel[i] = pinOe[i] ? pinOut[i] : (extOe[i] ? extVal[i] : 1'h1);
    end
  end

  // open strap reads high through its pull-up
  assign strapLevel = strapOe ? strapVal : 1'h1;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the gpio / status led pin block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gpio_led_pkg::*;
  localparam int TC    = 4;
  localparam int NT    = 3;
  localparam int BLINK = TC * NT;

  logic              clk, reset, read, write, waitrequest;
  logic [ADDR_W-1:0] address;
  logic [31:0]       writedata, readdata;
  logic [3:0]        byteenable;
  logic              phyLinkUp, phySpeed10, phyAutoNegBusy, phyFullDuplex;
  logic              phyTxActive, phyRxActive, strapOe, strapVal, strapLevel;
  logic              crossoverDetectEn;
  logic [2:0]        gpioOut, gpioOe, extVal, extOe, pinLevel;
  int                n_fail, checked;

  gpio_led_indicator_pins #(.TICK_CYC(TC), .N_TICKS(NT)) gpio_led_indicator_pins_i (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .phyLinkUp(phyLinkUp), .phySpeed10(phySpeed10),
    .phyAutoNegBusy(phyAutoNegBusy), .phyFullDuplex(phyFullDuplex),
    .phyTxActive(phyTxActive), .phyRxActive(phyRxActive),
    .crossover_auto_enable(strapLevel), .crossoverDetectEn(crossoverDetectEn),
    .gpioIn(pinLevel), .gpioOut(gpioOut), .gpioOe(gpioOe));

  board_pins board_pins_i (
    .pinOut(gpioOut), .pinOe(gpioOe), .extVal(extVal), .extOe(extOe),
    .strapOe(strapOe), .strapVal(strapVal), .pinLevel(pinLevel), .strapLevel(strapLevel));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 20);
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
    if (n >= 20) begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask

  task automatic rdm(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0000_0000, q);
    check(q & m, e);
  endtask

  // length of the current run of one level on the link/activity pin
  task automatic runlen(input logic v, output int n);
    n = 0;
    while (pinLevel[1] === v && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) begin
      n_fail++;
      stop_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdm(CFG_OFFSET, 32'hFFFF_FFFF, CFG_RESET);
    rdm(DATA_OFFSET, 32'hFFFF_FFFF, 32'h0000_0000);
    rdm(STAT_OFFSET, 32'h0000_0D17, 32'h0000_0817);
    rdm(4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
    check(32'(gpioOe), 32'h0000_0000);
    check(32'(crossoverDetectEn), 32'h0000_0001);
    $display("test reset done");
  endtask

  task automatic t_gpio();
    wr(CFG_OFFSET, 32'h0000_0700);
    wr(DATA_OFFSET, 32'h0000_0005);
    waitc(2);
    check(32'(gpioOe), 32'h0000_0007);
    check(32'(pinLevel), 32'h0000_0005);
    wr(CFG_OFFSET, 32'h0002_0700);
    wr(DATA_OFFSET, 32'h0000_0000);
    waitc(2);
    check(32'({gpioOe[1], gpioOut[1]}), 32'h0000_0002);
    wr(DATA_OFFSET, 32'h0000_0002);
    waitc(2);
    check(32'(gpioOe), 32'h0000_0005);
    wr(CFG_OFFSET, 32'h0000_0000);
    extOe <= 3'h7;
    extVal <= 3'h2;
    waitc(6);
    check(32'(gpioOe), 32'h0000_0000);
    rdm(STAT_OFFSET, 32'h0000_0007, 32'h0000_0002);
    wr(STAT_OFFSET, 32'hFFFF_FFFF);
    rdm(STAT_OFFSET, 32'h0000_0007, 32'h0000_0002);
    extOe <= 3'h0;
    $display("test gpio done");
  endtask

  task automatic t_led();
    wr(CFG_OFFSET, 32'h0007_0707);
    phyLinkUp <= 1'h1;
    phySpeed10 <= 1'h1;
    phyFullDuplex <= 1'h1;
    waitc(4);
    check(32'(pinLevel), 32'h0000_0001);
    check(32'(gpioOe & gpioOut), 32'h0000_0000);
    phyAutoNegBusy <= 1'h1;
    waitc(4);
    check(32'(pinLevel[0]), 32'h0000_0000);
    phyAutoNegBusy <= 1'h0;
    phySpeed10 <= 1'h0;
    waitc(4);
    check(32'(pinLevel[0]), 32'h0000_0000);
    phySpeed10 <= 1'h1;
    phyFullDuplex <= 1'h0;
    waitc(4);
    check(32'(pinLevel), 32'h0000_0005);
    phyLinkUp <= 1'h0;
    waitc(4);
    check(32'(pinLevel), 32'h0000_0006);
    $display("test led done");
  endtask

  task automatic t_blink();
    int n;
    phyLinkUp <= 1'h1;
    waitc(4);
    phyRxActive <= 1'h1;
    runlen(1'h0, n);
    runlen(1'h1, n);
    check(32'(n), 32'(BLINK));
    runlen(1'h0, n);
    check(32'(n), 32'(BLINK));
    phyRxActive <= 1'h0;
    runlen(1'h1, n);
    check(32'(n), 32'(BLINK));
    phyTxActive <= 1'h1;
    waitc(4);
    phyLinkUp <= 1'h0;
    phyTxActive <= 1'h0;
    waitc(4);
    check(32'(pinLevel[1]), 32'h0000_0001);
    $display("test blink done");
  endtask

  task automatic t_xover();
    strapOe <= 1'h1;
    strapVal <= 1'h0;
    waitc(6);
    check(32'(crossoverDetectEn), 32'h0000_0000);
    strapOe <= 1'h0;
    waitc(6);
    check(32'(crossoverDetectEn), 32'h0000_0001);
    $display("test crossover done");
  endtask

  task automatic t_reset2();
    wr(CFG_OFFSET, 32'h0000_0707);
    strapOe <= 1'h1;
    reset <= 1'h1;
    waitc(4);
    reset <= 1'h0;
    waitc(1);
    check(32'(gpioOe), 32'h0000_0000);
    check(32'(crossoverDetectEn), 32'h0000_0001);
    strapOe <= 1'h0;
    rdm(CFG_OFFSET, 32'hFFFF_FFFF, CFG_RESET);
    $display("test reset again done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, read, write, phyLinkUp, phySpeed10, phyAutoNegBusy} = 6'h20;
    {phyFullDuplex, phyTxActive, phyRxActive, strapOe, strapVal} = 5'h00;
    address = 4'h0;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    extVal = 3'h0;
    extOe = 3'h0;
    n_fail = 0;
    checked = 0;
    waitc(3);
    reset <= 1'h0;
    waitc(4);
    t_reset();
    t_gpio();
    t_led();
    t_blink();
    t_xover();
    t_reset2();
    stop_test();
  end
endmodule
`default_nettype wire
